/* File: core/eac_checker.sv */
`timescale 1ns/10ps
// enclave attribute checker: decodes and validates attribute, selector and protection words
//
// Overview of operation
// - capability bitmap input lists which attribute bits may be one
// - init bit must be zero at create; set only by initialize; the checker also takes it as one from a load outside create
// - debugger read and write allowed only with debug bit set
// - bit 2 selects wide mode, clear means non-wide enclave
// - provisioning key needs bit 4, launch token key needs bit 5
// - protection bit 6 reserved zero when capability bit 6 clear
// - bit 7 enables key separation and sharing
// - bit 10 permits exit notifications to enclave threads
// - bits 127:64 are the extended state request mask
// - capability word lists extra info kinds savable on exit
// - zero capability word forces selector to all zero; the checker only clears sel_valid, bit 0 still selects fault info
// - on exit store only selected extra info kinds
// - save region size derives from the selector
// - selector bit 0 records page and protection fault details
// - selector bit 1 needs capability bit 1; bits 31:2 zero
// - protection byte exists only with capability bit 6
// - byte bits 1:0 need shadow stack, 5:2 tracking, 7:6 zero
// - byte bit 0 enables shadow stacks
// - byte bit 1 enables shadow stack write instructions
// - byte bit 2 enables indirect branch tracking
// - bits 3,4,5: legacy treatment, no-track prefix, suppression disable
module eac_checker
	import eac_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         reset,
	// capability enumeration inputs
	input  wire logic [127:0] attr_cap_bitmap,
	input  wire logic [31:0]  sel_cap,
	input  wire logic         ss_support,
	input  wire logic         bt_support,
	// load request: one attribute, selector and protection set
	input  wire logic         load_valid,
	input  wire logic         load_is_create,
	input  wire logic [127:0] attr_word,
	input  wire logic [31:0]  sel_word,
	input  wire logic [7:0]   prot_byte,
	// operation requests
	input  wire logic         enclave_initialize_op,
	input  wire logic         debugger_read_op,
	input  wire logic         debugger_write_op,
	input  wire logic         key_derive_op,
	input  wire logic         key_is_provisioning,
	input  wire logic         asynchronous_exit,
	// results
	output logic              check_done,
	output logic              attr_valid,
	output logic              sel_valid,
	output logic              prot_valid,
	output logic [127:0]      attr_current,
	output logic              debugger_access_grant,
	output logic              key_grant,
	output logic              wide_mode_flag,
	output logic              key_separation_enable,
	output logic              exit_notify_allow,
	output logic [63:0]       extended_state_request_mask,
	output logic              fault_info_select,
	output logic              control_protection_info_select,
	output logic [15:0]       save_region_bytes,
	output logic              exit_store_valid,
	output logic [1:0]        exit_store_kinds,
	output logic              shadow_stack_enable,
	output logic              shadow_stack_write_enable,
	output logic              branch_tracking_enable,
	output logic              legacy_compat_enable,
	output logic              no_track_enable,
	output logic              tracking_suppression_disable
);

	typedef struct packed {
		eac_state_type  fsm;
		logic [127:0]   attr;
		logic [31:0]    sel;
		logic [7:0]     prot;
		logic           attr_ok;
		logic           done;
		logic           dbg;
		logic           key;
		logic           xstore;
		logic [1:0]     xkinds;
	} eac_core_type;

	eac_core_type state;
	eac_core_type next_state;

	logic       sel_ok;
	logic       prot_ok;
	logic [5:0] prot_en;
	logic       fault_sel;
	logic       cprot_sel;

	// attribute legality against capability bitmap and reserved positions
	function automatic logic attr_legal(input logic [127:0] a,
		input logic [127:0] cap, input logic create);
		logic ok;
		ok = ((a & ~cap) == 128'h0);
		ok = ok && ((a[63:0] & ATTR_RSVD_MASK) == 64'h0);
		ok = ok && !(a[ATTR_PROT_BIT] && !cap[ATTR_PROT_BIT]);
		ok = ok && !(create && a[ATTR_INIT_BIT]);
		return ok;
	endfunction

	// selector and protection byte checks run on the held copies one cycle after the attribute check
	eac_sel_decode u_sel (
		.clk_sys                        (clk_sys),
		.reset                          (reset),
		.sel_word                       (state.sel),
		.sel_cap                        (sel_cap),
		.sel_ok                         (sel_ok),
		.fault_info_select              (fault_sel),
		.control_protection_info_select (cprot_sel),
		.save_region_bytes              (save_region_bytes)
	);

	eac_prot_decode u_prot (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.prot_byte    (state.prot),
		.prot_present (state.attr[ATTR_PROT_BIT] & attr_cap_bitmap[CAP_PROT_BIT]),
		.ss_support   (ss_support),
		.bt_support   (bt_support),
		.prot_ok      (prot_ok),
		.prot_enables (prot_en)
	);

	// next state: load, one cycle for the decoders, then results stand
	always_comb begin
		next_state        = state;
		next_state.done   = 1'b0;
		next_state.dbg    = 1'b0;
		next_state.key    = 1'b0;
		next_state.xstore = 1'b0;
		next_state.xkinds = 2'b00;
		case (state.fsm)
			EAC_IDLE: begin
				if (load_valid) begin
					next_state.attr    = attr_word;
					next_state.sel     = sel_word;
					next_state.prot    = prot_byte;
					next_state.attr_ok = attr_legal(attr_word, attr_cap_bitmap,
						load_is_create);
					next_state.fsm     = EAC_CHECK;
				end
			end
			EAC_CHECK: begin
				next_state.fsm = EAC_DONE;
			end
			EAC_DONE: begin
				next_state.done = 1'b1;
				next_state.fsm  = EAC_IDLE;
			end
			default: begin
				next_state.fsm = EAC_IDLE;
			end
		endcase
		// init is set by the initialize operation on a valid enclave, or by a load outside create with bit 0 one
		if (enclave_initialize_op && state.attr_ok && !load_valid) begin
			next_state.attr[ATTR_INIT_BIT] = 1'b1;
		end
		// debugger access gated by debug bit
		next_state.dbg = (debugger_read_op | debugger_write_op)
			& state.attr[ATTR_DEBUG_BIT];
		// key selection: provisioning needs bit 4, launch token needs bit 5
		if (key_derive_op) begin
			next_state.key = key_is_provisioning ? state.attr[ATTR_PROV_BIT]
				: state.attr[ATTR_LTOKEN_BIT];
		end
		// on exit only the selected kinds are stored; control protection info also needs its capability bit
		if (asynchronous_exit) begin
			next_state.xstore = fault_sel | cprot_sel;
			next_state.xkinds = {cprot_sel, fault_sel};
		end
	end

	// single register for the whole core state
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= '{fsm: EAC_IDLE, attr: ATTR_RESET, sel: SEL_RESET,
				prot: PROT_RESET, default: '0};
		end else begin
			state <= next_state;
		end
	end

	// results from the held state and the decoders; field outputs straight from the held attribute word
	assign check_done                     = state.done;
	assign attr_valid                     = state.attr_ok;
	assign sel_valid                      = sel_ok;
	assign prot_valid                     = prot_ok;
	assign attr_current                   = state.attr;
	assign debugger_access_grant          = state.dbg;
	assign key_grant                      = state.key;
	assign wide_mode_flag                 = state.attr[ATTR_WIDE_BIT];
	assign key_separation_enable          = state.attr[ATTR_KSEP_BIT];
	assign exit_notify_allow              = state.attr[ATTR_NOTIFY_BIT];
	assign extended_state_request_mask    = state.attr[ATTR_XMASK_LSB +: ATTR_XMASK_W];
	assign fault_info_select              = fault_sel;
	assign control_protection_info_select = cprot_sel;
	assign exit_store_valid               = state.xstore;
	assign exit_store_kinds               = state.xkinds;
	// protection enables are zero unless the field exists and is supported
	assign shadow_stack_enable            = prot_en[PROT_SS_BIT];
	assign shadow_stack_write_enable      = prot_en[PROT_SSW_BIT];
	assign branch_tracking_enable         = prot_en[PROT_BT_BIT];
	assign legacy_compat_enable           = prot_en[PROT_LEG_BIT];
	assign no_track_enable                = prot_en[PROT_NOTRK_BIT];
	assign tracking_suppression_disable   = prot_en[PROT_SUPD_BIT];

	// checks
	chk_init_at_create: assert property (@(posedge clk_sys) disable iff (reset)
		(state.fsm == EAC_IDLE && load_valid && load_is_create && attr_word[0])
		|=> !attr_valid)
		else $error("create accepted with init bit set");

	chk_outside_bitmap: assert property (@(posedge clk_sys) disable iff (reset)
		(state.fsm == EAC_IDLE && load_valid && ((attr_word & ~attr_cap_bitmap) != '0))
		|=> !attr_valid)
		else $error("attribute accepted outside bitmap");

	chk_reserved_attr: assert property (@(posedge clk_sys) disable iff (reset)
		(state.fsm == EAC_IDLE && load_valid && attr_word[3]) |=> !attr_valid)
		else $error("reserved attribute bit 3 accepted");

	chk_prot_attr_cap: assert property (@(posedge clk_sys) disable iff (reset)
		(state.fsm == EAC_IDLE && load_valid && attr_word[6] && !attr_cap_bitmap[6])
		|=> !attr_valid)
		else $error("protection attribute accepted without capability");

	chk_debug_gate: assert property (@(posedge clk_sys) disable iff (reset)
		debugger_access_grant |-> $past(state.attr[ATTR_DEBUG_BIT])
		&& ($past(debugger_read_op) || $past(debugger_write_op)))
		else $error("debugger access without debug bit");

	chk_key_gate: assert property (@(posedge clk_sys) disable iff (reset)
		(key_derive_op && key_is_provisioning && !state.attr[ATTR_PROV_BIT]
		&& !load_valid && !enclave_initialize_op) |=> !key_grant)
		else $error("provisioning key granted without bit 4");

	chk_check_latency: assert property (@(posedge clk_sys) disable iff (reset)
		(state.fsm == EAC_IDLE && load_valid) |-> ##3 check_done)
		else $error("check result not ready three cycles after load");

	chk_exit_store: assert property (@(posedge clk_sys) disable iff (reset)
		asynchronous_exit |=> exit_store_kinds == {$past(cprot_sel), $past(fault_sel)})
		else $error("exit store kinds differ from selector");

	// compares against the word on the load pins, not the held copy, so a wrong field tap shows
	chk_wide_mode: assert property (@(posedge clk_sys) disable iff (reset)
		(state.fsm == EAC_IDLE && load_valid)
		|=> wide_mode_flag == $past(attr_word[ATTR_WIDE_BIT]))
		else $error("wide mode flag disagrees with loaded attribute");

	cov_create_ok: cover property (@(posedge clk_sys) disable iff (reset)
		check_done && attr_valid && sel_valid && prot_valid);
	cov_init_set: cover property (@(posedge clk_sys) disable iff (reset)
		enclave_initialize_op ##1 attr_current[0]);
	cov_debug_grant: cover property (@(posedge clk_sys) disable iff (reset)
		debugger_access_grant);
	cov_exit_store: cover property (@(posedge clk_sys) disable iff (reset)
		exit_store_valid && exit_store_kinds == 2'b11);

endmodule // eac_checker

/* File: core/eac_prot_decode.sv */
`timescale 1ns/10ps
// protection attribute byte decoder with support gating
module eac_prot_decode
	import eac_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] prot_byte,
	input  wire logic       prot_present,
	input  wire logic       ss_support,
	input  wire logic       bt_support,
	output logic            prot_ok,
	output logic [5:0]      prot_enables
);

	typedef struct packed {
		logic       ok;
		logic [5:0] en;
	} eac_prot_type;

	eac_prot_type state;
	eac_prot_type next_state;

	// bits only count when the field exists and its feature is enumerated
	always_comb begin
		logic [7:0] defined;
		defined         = 8'h0;
		next_state      = state;
		if (prot_present) begin
			defined = (ss_support ? PROT_SS_MASK : 8'h0)
				| (bt_support ? PROT_BT_MASK : 8'h0);
		end
		next_state.en = prot_byte[5:0] & defined[5:0];
		next_state.ok = ((prot_byte & ~defined) == 8'h0)
			&& ((prot_byte & PROT_RSVD_MASK) == 8'h0);
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign prot_ok      = state.ok;
	assign prot_enables = state.en;

	chk_prot_rsvd_bits: assert property (@(posedge clk_sys) disable iff (reset)
		(prot_byte[7:6] != 2'b00) |=> !prot_ok)
		else $error("reserved protection bits accepted");

endmodule // eac_prot_decode

/* File: core/eac_sel_decode.sv */
`timescale 1ns/10ps
// selector decoder: checks the extra info selector and sizes the save region
module eac_sel_decode
	import eac_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [31:0] sel_word,
	input  wire logic [31:0] sel_cap,
	output logic             sel_ok,
	output logic             fault_info_select,
	output logic             control_protection_info_select,
	output logic [15:0]      save_region_bytes
);

	typedef struct packed {
		logic        ok;
		logic        fault;
		logic        cprot;
		logic [15:0] bytes;
	} eac_sel_type;

	eac_sel_type state;
	eac_sel_type next_state;

	// validity and region size are registered so all outputs come from flip-flops
	always_comb begin
		next_state       = state;
		next_state.fault = sel_word[SEL_FAULT_BIT];
		next_state.cprot = sel_word[SEL_CPROT_BIT] & sel_cap[CAP_CPROT_BIT];
		// a zero capability makes any nonzero selector invalid
		next_state.ok    = ((sel_word & ~sel_cap) == 32'h0)
			&& ((sel_word & SEL_RSVD_MASK) == 32'h0);
		next_state.bytes = (sel_word[SEL_FAULT_BIT] ? SEL_FAULT_BYTES : 16'h0)
			+ (sel_word[SEL_CPROT_BIT] ? SEL_CPROT_BYTES : 16'h0);
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sel_ok                         = state.ok;
	assign fault_info_select              = state.fault;
	assign control_protection_info_select = state.cprot;
	assign save_region_bytes              = state.bytes;

	chk_sel_cap_zero: assert property (@(posedge clk_sys) disable iff (reset)
		(sel_cap == 32'h0 && sel_word != 32'h0) |=> !sel_ok)
		else $error("nonzero selector accepted with zero capability");

endmodule // eac_sel_decode

/* File: dv/eac_tb.sv */
// self-checking testbench for the enclave attribute checker
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h expected %h", $time, (got), (exp)); end end
module testbench
	import eac_pkg::*;
;
	logic         clk_sys, reset, ss_support, bt_support, load_valid, load_is_create;
	logic [127:0] attr_cap_bitmap, attr_word, attr_current;
	logic [31:0]  sel_cap, sel_word;
	logic [7:0]   prot_byte;
	logic         enclave_initialize_op, debugger_read_op, debugger_write_op;
	logic         key_derive_op, key_is_provisioning, asynchronous_exit;
	logic         check_done, attr_valid, sel_valid, prot_valid, debugger_access_grant;
	logic         key_grant, wide_mode_flag, key_separation_enable, exit_notify_allow;
	logic [63:0]  extended_state_request_mask;
	logic         fault_info_select, control_protection_info_select, exit_store_valid;
	logic [15:0]  save_region_bytes;
	logic [1:0]   exit_store_kinds;
	logic         shadow_stack_enable, shadow_stack_write_enable, branch_tracking_enable;
	logic         legacy_compat_enable, no_track_enable, tracking_suppression_disable;
	logic [5:0]   en;
	int           mismatches, comparisons, cycles;
	int           bad_bits[7] = '{0, 3, 8, 9, 11, 63, 72};
	logic [31:0]  bad_caps[3] = '{32'h0, 32'h1, 32'h3};
	logic [31:0]  bad_sels[3] = '{32'h1, 32'h2, 32'h4};
	// enables gathered in byte bit order for one compare
	assign en = {tracking_suppression_disable, no_track_enable, legacy_compat_enable,
		branch_tracking_enable, shadow_stack_write_enable, shadow_stack_enable};

	eac_checker DUT (.clk_sys(clk_sys), .reset(reset), .attr_cap_bitmap(attr_cap_bitmap),
		.sel_cap(sel_cap), .ss_support(ss_support), .bt_support(bt_support),
		.load_valid(load_valid), .load_is_create(load_is_create), .attr_word(attr_word),
		.sel_word(sel_word), .prot_byte(prot_byte),
		.enclave_initialize_op(enclave_initialize_op), .debugger_read_op(debugger_read_op),
		.debugger_write_op(debugger_write_op), .key_derive_op(key_derive_op),
		.key_is_provisioning(key_is_provisioning), .asynchronous_exit(asynchronous_exit),
		.check_done(check_done), .attr_valid(attr_valid), .sel_valid(sel_valid),
		.prot_valid(prot_valid), .attr_current(attr_current),
		.debugger_access_grant(debugger_access_grant), .key_grant(key_grant),
		.wide_mode_flag(wide_mode_flag), .key_separation_enable(key_separation_enable),
		.exit_notify_allow(exit_notify_allow),
		.extended_state_request_mask(extended_state_request_mask),
		.fault_info_select(fault_info_select),
		.control_protection_info_select(control_protection_info_select),
		.save_region_bytes(save_region_bytes), .exit_store_valid(exit_store_valid),
		.exit_store_kinds(exit_store_kinds), .shadow_stack_enable(shadow_stack_enable),
		.shadow_stack_write_enable(shadow_stack_write_enable),
		.branch_tracking_enable(branch_tracking_enable),
		.legacy_compat_enable(legacy_compat_enable), .no_track_enable(no_track_enable),
		.tracking_suppression_disable(tracking_suppression_disable));

	// 200 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// prints the counts and the verdict, then stops
	task results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			results();
		end
	end

	// one load request, then a bounded wait for the done pulse; loads stay 3+ cycles apart
	task automatic load(input logic [127:0] a, input logic [31:0] s, input logic [7:0] p,
		input logic cr);
		int n;
		@(posedge clk_sys);
		load_valid <= 1'b1;
		attr_word <= a;
		sel_word <= s;
		prot_byte <= p;
		load_is_create <= cr;
		@(posedge clk_sys);
		load_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (check_done !== 1'b1 && n < 8);
		`CHK(check_done, 1'b1)
	endtask

	// one-cycle operation pulse; returns once the registered answer is visible
	task automatic op(input int k, input logic prov);
		@(posedge clk_sys);
		key_is_provisioning <= prov;
		case (k)
			0: debugger_read_op <= 1'b1;
			1: debugger_write_op <= 1'b1;
			2: key_derive_op <= 1'b1;
			3: asynchronous_exit <= 1'b1;
			default: enclave_initialize_op <= 1'b1;
		endcase
		@(posedge clk_sys);
		{debugger_read_op, debugger_write_op, key_derive_op, asynchronous_exit} <= 4'h0;
		enclave_initialize_op <= 1'b0;
		#1;
	endtask

	initial begin
		{reset, ss_support, bt_support, load_valid, load_is_create} = 5'b11100;
		{enclave_initialize_op, debugger_read_op, debugger_write_op} = 3'b000;
		{key_derive_op, key_is_provisioning, asynchronous_exit} = 3'b000;
		attr_cap_bitmap = {64'h0000_0000_0000_00ff, 64'h0000_0000_0000_04f7};
		{attr_word, sel_word, prot_byte, sel_cap} = '0;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		repeat (12) @(posedge clk_sys);
		#1;
		`CHK(attr_current, ATTR_RESET)
		`CHK({attr_valid, sel_valid, check_done}, 3'b000)
		@(posedge clk_sys);
		reset <= 1'b0;
		$display("test reset done");
		// full valid create with every field except init bit 0 and launch token bit 5, and both selector kinds
		sel_cap <= 32'h3;
		load({64'h3, 64'h4d6}, 32'h3, 8'h3f, 1'b1);
		`CHK(attr_valid, 1'b1)
		`CHK(attr_current, {64'h3, 64'h4d6})
		`CHK({wide_mode_flag, key_separation_enable}, 2'b11)
		`CHK(exit_notify_allow, 1'b1)
		`CHK(extended_state_request_mask, 64'h3)
		`CHK({sel_valid, fault_info_select}, 2'b11)
		`CHK(control_protection_info_select, 1'b1)
		`CHK(save_region_bytes, SEL_FAULT_BYTES + SEL_CPROT_BYTES)
		`CHK({prot_valid, en}, 7'h7f)
		op(0, 1'b0);
		`CHK(debugger_access_grant, 1'b1)
		op(1, 1'b0);
		`CHK(debugger_access_grant, 1'b1)
		op(2, 1'b1);
		`CHK(key_grant, 1'b1)
		op(2, 1'b0);
		`CHK(key_grant, 1'b0)
		op(3, 1'b0);
		`CHK({exit_store_valid, exit_store_kinds}, 3'b111)
		op(4, 1'b0);
		@(posedge clk_sys);
		#1;
		`CHK(attr_current[ATTR_INIT_BIT], 1'b1)
		$display("test full create done");
		// plain enclave: no debug, 32-bit, launch key only, fault info only
		sel_cap <= 32'h1;
		ss_support <= 1'b0;
		load({64'h0, 64'h20}, 32'h1, 8'h3f, 1'b0);
		`CHK({attr_valid, wide_mode_flag, exit_notify_allow}, 3'b100)
		`CHK(en, 6'h00)
		`CHK({sel_valid, control_protection_info_select}, 2'b10)
		`CHK(save_region_bytes, SEL_FAULT_BYTES)
		op(1, 1'b0);
		`CHK(debugger_access_grant, 1'b0)
		op(2, 1'b0);
		`CHK(key_grant, 1'b1)
		op(2, 1'b1);
		`CHK(key_grant, 1'b0)
		op(3, 1'b0);
		`CHK({exit_store_valid, exit_store_kinds}, 3'b101)
		$display("test plain enclave done");
		// protection byte with only tracking support, then a reserved byte bit
		load({64'h0, 64'h40}, 32'h0, 8'h3f, 1'b1);
		`CHK(en, 6'h3c)
		load({64'h0, 64'h40}, 32'h0, 8'h40, 1'b1);
		`CHK(prot_valid, 1'b0)
		$display("test protection byte done");
		// reserved, create-time init and unpermitted bits each spoil the word
		foreach (bad_bits[i]) begin
			load(128'h1 << bad_bits[i], 32'h0, 8'h0, 1'b1);
			`CHK(attr_valid, 1'b0)
		end
		// init op is ignored while the held word is invalid
		op(4, 1'b0);
		@(posedge clk_sys);
		#1;
		`CHK(attr_current[ATTR_INIT_BIT], 1'b0)
		attr_cap_bitmap <= {64'h0000_0000_0000_00ff, 64'h0000_0000_0000_0497};
		load({64'h0, 64'h20}, 32'h0, 8'h0, 1'b1);
		`CHK(attr_valid, 1'b0)
		load({64'h0, 64'h40}, 32'h0, 8'h0, 1'b1);
		`CHK(attr_valid, 1'b0)
		$display("test invalid attributes done");
		// selector against capability: zero capability, missing bit 1, reserved bit
		foreach (bad_caps[i]) begin
			sel_cap <= bad_caps[i];
			load(128'h0, bad_sels[i], 8'h0, 1'b1);
			`CHK(sel_valid, 1'b0)
		end
		$display("test selector done");
		// a second load one cycle into the check is dropped
		@(posedge clk_sys);
		load_valid <= 1'b1;
		attr_word <= {64'h0, 64'h4};
		@(posedge clk_sys);
		attr_word <= {64'h0, 64'h400};
		@(posedge clk_sys);
		load_valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK({wide_mode_flag, exit_notify_allow}, 2'b10)
		$display("test refused load done");
		// report target words are loaded with init already one, outside create
		load({64'h0, 64'h1}, 32'h0, 8'h0, 1'b0);
		`CHK({attr_valid, attr_current[ATTR_INIT_BIT]}, 2'b11)
		$display("test report target done");
		results();
	end
endmodule // testbench

/* File: pkg/eac_pkg.sv */
// package of field positions, masks and reset values for the enclave attribute checker
package eac_pkg;

	// attribute word field positions
	localparam int ATTR_W            = 128;
	localparam int ATTR_INIT_BIT     = 0;
	localparam int ATTR_DEBUG_BIT    = 1;
	localparam int ATTR_WIDE_BIT     = 2;
	localparam int ATTR_PROV_BIT     = 4;
	localparam int ATTR_LTOKEN_BIT   = 5;
	localparam int ATTR_PROT_BIT     = 6;
	localparam int ATTR_KSEP_BIT     = 7;
	localparam int ATTR_NOTIFY_BIT   = 10;
	localparam int ATTR_XMASK_LSB    = 64;
	localparam int ATTR_XMASK_W      = 64;

	// bits that are reserved zero in the low half (3, 63:11)
	localparam logic [63:0] ATTR_RSVD_MASK = 64'hffff_ffff_ffff_f808;

	// extra info selector fields
	localparam int SEL_W             = 32;
	localparam int SEL_FAULT_BIT     = 0;
	localparam int SEL_CPROT_BIT     = 1;
	localparam logic [31:0] SEL_RSVD_MASK = 32'hffff_fffc;

	// per-kind save region sizes in bytes
	localparam logic [15:0] SEL_FAULT_BYTES = 16'h0010;
	localparam logic [15:0] SEL_CPROT_BYTES = 16'h0010;

	// protection attribute byte fields
	localparam int PROT_W            = 8;
	localparam int PROT_SS_BIT       = 0;
	localparam int PROT_SSW_BIT      = 1;
	localparam int PROT_BT_BIT       = 2;
	localparam int PROT_LEG_BIT      = 3;
	localparam int PROT_NOTRK_BIT    = 4;
	localparam int PROT_SUPD_BIT     = 5;
	localparam logic [7:0] PROT_SS_MASK   = 8'h03;
	localparam logic [7:0] PROT_BT_MASK   = 8'h3c;
	localparam logic [7:0] PROT_RSVD_MASK = 8'hc0;

	// capability bits
	localparam int CAP_PROT_BIT      = 6;
	localparam int CAP_CPROT_BIT     = 1;

	// reset values
	localparam logic [127:0] ATTR_RESET = 128'h0;
	localparam logic [31:0]  SEL_RESET  = 32'h0;
	localparam logic [7:0]   PROT_RESET = 8'h0;

	// check pipeline states
	typedef enum logic [1:0] {
		EAC_IDLE,
		EAC_CHECK,
		EAC_DONE
	} eac_state_type;

endpackage
